// ### hw/rtp_pins.sv
// Reset pin, power-drive trip and shared pin routing with a Wishbone register file
// Function
// - Low reset halts execution, counter zero
// - Reset release starts fetch at zero
// - Watchdog pulls reset low 128 clocks
// - Reset pin only released, never driven high
// - Trip low interrupts and floats PWM outputs
// - Halt clears the mux, so pins fall back to GPIO
// - Trip active with gpio_a0 after reset
// - Mask bit zero clear disables trip
// - Pin carries timer PWM, irq one, gpio_b0
// - Pin carries irq two, ADC, capture, clock
// - Compare outputs share gpio_a1 to a3
// - Bit eight routes timer PWM out
// - Irq one ignores bit eight
// - Bit seven drives CPU clock out
// - Clock out selected, inputs see one
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/100ps
module rtp_pins
	import rtp_pkg::*;
#(
	parameter int WDOG_LEN = WDOG_PULL_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq_o,
	input  wire logic        wd_reset_i,
	input  wire logic        pc_step_i,
	output logic      [15:0] program_counter_o,
	output logic             cpu_run_o,
	input  wire logic        rst_pin_i,
	output logic             rst_pin_o,
	output logic             rst_pin_oe_n_o,
	input  wire logic [3:0]  pa_pin_i,
	output logic      [3:0]  pa_pin_o,
	output logic      [3:0]  pa_pin_oe_n_o,
	input  wire logic [2:0]  cmp_i,
	input  wire logic [2:0]  cmp_en_i,
	input  wire logic [3:0]  gpio_a_out_i,
	input  wire logic [3:0]  gpio_a_dir_i,
	output logic      [3:0]  gpio_a_in_o,
	input  wire logic        tmr_pin_i,
	output logic             tmr_pin_o,
	output logic             tmr_pin_oe_n_o,
	input  wire logic        timer2_pwm_out_i,
	input  wire logic        gpio_b0_out_i,
	input  wire logic        gpio_b0_dir_i,
	output logic             gpio_b0_in_o,
	output logic             ext_irq_one_o,
	input  wire logic        clk_pin_i,
	output logic             clk_pin_o,
	output logic             clk_pin_oe_n_o,
	input  wire logic        cpu_clock_out_i,
	input  wire logic        gpio_a7_out_i,
	input  wire logic        gpio_a7_dir_i,
	output logic             gpio_a7_in_o,
	output logic             ext_irq_two_o,
	output logic             adc_start_pin_o,
	output logic             capture_input_one_o
);
	logic [SYN_W-1:0]    syn;
	logic                wd_pull;
	logic                dev_rst;
	logic [15:0]         mux_control_a;
	logic [15:0]         event_irq_mask_a;
	logic [IRQ_BITS-1:0] irq_stat;
	logic [IRQ_BITS-1:0] irq_mask;
	logic [IRQ_BITS-1:0] irq_set;
	logic                trip_prev;
	logic                trip_en;
	logic                pwm_forced;
	logic                wb_req;
	logic                wb_wr;
	logic [31:0]         wmask;
	logic [31:0]         rd_val;
	// Byte enables expanded into a bit mask
	function automatic logic [31:0] sel_mask(input logic [3:0] sel);
		sel_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : sel_mask

	// Merge a masked write into a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [31:0] m);
		merge16 = (old & ~m[15:0]) | (d[15:0] & m[15:0]);
	endfunction : merge16

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and watchdog stretch

	rtp_sync #(
		.W    (SYN_W),
		.IDLE (SYN_IDLE)
	) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({tmr_pin_i, clk_pin_i, pa_pin_i, rst_pin_i}),
		.q_o   (syn)
	);

	rtp_wdog_pull #(
		.LEN (WDOG_LEN)
	) u_wdog (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.wd_reset_i (wd_reset_i),
		.pull_o     (wd_pull)
	);

	assign rst_pin_o      = 1'b0;
	assign rst_pin_oe_n_o = ~wd_pull;
	// Core reset from bus reset or a low reset pin
	assign dev_rst        = rst_i | ~syn[SYN_RST];

	////////////////////////////////////////////////////////////////////////////
	// Program counter

	always_ff @(posedge clk_i) begin
		if (dev_rst) begin
			program_counter_o <= PC_START;
			cpu_run_o         <= 1'b0;
		end else begin
			cpu_run_o <= 1'b1;
			if (cpu_run_o && pc_step_i) begin
				program_counter_o <= program_counter_o + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power-drive trip

	assign trip_en    = event_irq_mask_a[EV_TRIP_EN_BIT];
	assign pwm_forced = trip_en & ~pa_pin_i[0];

	// Falling edge detect on the synchronised trip level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trip_prev <= 1'b1;
		end else begin
			trip_prev <= syn[SYN_PA0];
		end
	end

	assign irq_set[IRQ_TRIP_BIT] = trip_en & trip_prev & ~syn[SYN_PA0];
	assign irq_set[IRQ_WDOG_BIT] = wd_reset_i & ~wd_pull;

	////////////////////////////////////////////////////////////////////////////
	// Pin routing

	always_comb begin
		pa_pin_o[0]      = gpio_a_out_i[0];
		pa_pin_oe_n_o[0] = ~gpio_a_dir_i[0];
		for (int i = 0; i < NUM_CMP; i++) begin
			if (mux_control_a[MUX_CMP1_BIT + i]) begin
				pa_pin_o[i + 1]      = cmp_i[i];
				pa_pin_oe_n_o[i + 1] = ~cmp_en_i[i] | pwm_forced;
			end else begin
				pa_pin_o[i + 1]      = gpio_a_out_i[i + 1];
				pa_pin_oe_n_o[i + 1] = ~gpio_a_dir_i[i + 1];
			end
		end
	end
	assign gpio_a_in_o = syn[SYN_PA0 +: 4];

	always_comb begin
		if (mux_control_a[MUX_TIMER2_PWM_OUT_BIT]) begin
			tmr_pin_o      = timer2_pwm_out_i;
			tmr_pin_oe_n_o = pwm_forced;
		end else begin
			tmr_pin_o      = gpio_b0_out_i;
			tmr_pin_oe_n_o = ~gpio_b0_dir_i;
		end
	end
	assign ext_irq_one_o = syn[SYN_P31];
	assign gpio_b0_in_o  = syn[SYN_P31];

	always_comb begin
		if (mux_control_a[MUX_CPU_CLOCK_OUT_BIT]) begin
			clk_pin_o           = cpu_clock_out_i;
			clk_pin_oe_n_o      = 1'b0;
			ext_irq_two_o       = 1'b1;
			adc_start_pin_o     = 1'b1;
			capture_input_one_o = 1'b1;
		end else begin
			clk_pin_o           = gpio_a7_out_i;
			clk_pin_oe_n_o      = ~gpio_a7_dir_i;
			ext_irq_two_o       = syn[SYN_P22];
			adc_start_pin_o     = syn[SYN_P22];
			capture_input_one_o = syn[SYN_P22];
		end
	end
	assign gpio_a7_in_o = syn[SYN_P22];

	////////////////////////////////////////////////////////////////////////////
	// Wishbone slave

	assign wb_req = wb_cyc_i & wb_stb_i;
	assign wb_wr  = wb_req & wb_we_i & wb_ack_o;
	assign wmask  = sel_mask(wb_sel_i);

	// One wait state, ack drops the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req & ~wb_ack_o;
		end
	end

	// Read decode; unmapped addresses read zero
	always_comb begin
		rd_val = 32'h0000_0000;
		if (wb_adr_i == ADR_MUX_CTRL) begin
			rd_val[15:0] = mux_control_a;
		end else if (wb_adr_i == ADR_EV_MASK) begin
			rd_val[15:0] = event_irq_mask_a;
		end else if (wb_adr_i == ADR_IRQ_STAT) begin
			rd_val[IRQ_BITS-1:0] = irq_stat;
		end else if (wb_adr_i == ADR_IRQ_MASK) begin
			rd_val[IRQ_BITS-1:0] = irq_mask;
		end else if (wb_adr_i == ADR_PIN_STATE) begin
			rd_val[ST_TRIP_BIT]   = syn[SYN_PA0];
			rd_val[ST_RSTPIN_BIT] = syn[SYN_RST];
			rd_val[ST_WDOG_BIT]   = wd_pull;
			rd_val[ST_FORCED_BIT] = pwm_forced;
		end
	end

	// Read data captured with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_req & ~wb_ack_o) begin
			wb_dat_o <= rd_val;
		end
	end

	// Pin configuration registers, also reset by the reset pin (mux cleared, trip enable set)
	always_ff @(posedge clk_i) begin
		if (dev_rst) begin
			mux_control_a    <= MUX_CTRL_RST;
			event_irq_mask_a <= EV_MASK_RST;
		end else if (wb_wr && wb_adr_i == ADR_MUX_CTRL) begin
			mux_control_a <= merge16(mux_control_a, wb_dat_i, wmask);
		end else if (wb_wr && wb_adr_i == ADR_EV_MASK) begin
			event_irq_mask_a <= merge16(event_irq_mask_a, wb_dat_i, wmask);
		end
	end

	// Sticky status, write one to clear, a new event wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= IRQ_RST;
		end else if (wb_wr && wb_adr_i == ADR_IRQ_STAT) begin
			irq_stat <= (irq_stat & ~(wb_dat_i[IRQ_BITS-1:0] & wmask[IRQ_BITS-1:0])) | irq_set;
		end else begin
			irq_stat <= irq_stat | irq_set;
		end
	end

	// Interrupt mask
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask <= IRQ_RST;
		end else if (wb_wr && wb_adr_i == ADR_IRQ_MASK) begin
			irq_mask <= IRQ_BITS'(merge16(16'(irq_mask), wb_dat_i, wmask));
		end
	end

	assign irq_o = |(irq_stat & irq_mask);

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	logic [8:0] pull_len;
	always_ff @(posedge clk_i) begin
		if (rst_i || !wd_pull) begin
			pull_len <= 9'h000;
		end else begin
			pull_len <= pull_len + 9'h001;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	pc_halt_zero_a: assert property (
		!syn[SYN_RST] |=> program_counter_o == PC_START && !cpu_run_o)
		else $error("pc not held at zero in reset");
	fetch_start_a: assert property ($rose(cpu_run_o) |-> program_counter_o == PC_START)
		else $error("fetch did not start at zero");
	wdog_len_a: assert property ($fell(wd_pull) |-> $past(pull_len) == 9'(WDOG_LEN - 1))
		else $error("watchdog pull length wrong");
	od_release_a: assert property (rst_pin_oe_n_o == !wd_pull && rst_pin_o == 1'b0)
		else $error("reset pin driven high");
	trip_float_a: assert property (pwm_forced |->
		tmr_pin_oe_n_o || !mux_control_a[MUX_TIMER2_PWM_OUT_BIT])
		else $error("timer pwm driven during trip");
	trip_irq_a: assert property (trip_en && $fell(syn[SYN_PA0]) |=> irq_stat[IRQ_TRIP_BIT])
		else $error("trip interrupt not raised");
	trip_off_a: assert property (!trip_en && !irq_stat[IRQ_TRIP_BIT] |->
		!pwm_forced ##1 !irq_stat[IRQ_TRIP_BIT])
		else $error("disabled trip still acts");
	timer2_pwm_out_sel_a: assert property (mux_control_a[MUX_TIMER2_PWM_OUT_BIT] && !pwm_forced |->
		tmr_pin_o == timer2_pwm_out_i && !tmr_pin_oe_n_o)
		else $error("timer pwm not routed");
	irq_one_a: assert property (ext_irq_one_o == syn[SYN_P31])
		else $error("irq one depends on mux");
	clk_out_a: assert property (mux_control_a[MUX_CPU_CLOCK_OUT_BIT] |->
		ext_irq_two_o && adc_start_pin_o && capture_input_one_o && !clk_pin_oe_n_o)
		else $error("clock out inputs not forced high");

	wdog_cover_c: cover property ($rose(wd_pull) ##[1:200] $fell(wd_pull));
	trip_cover_c: cover property (trip_en && $fell(syn[SYN_PA0]) ##1 irq_o);
	cpu_clock_out_cover_c: cover property ($rose(mux_control_a[MUX_CPU_CLOCK_OUT_BIT]));
endmodule : rtp_pins

// ### hw/rtp_pkg.sv
// Shared constants for the reset pin, power-drive trip and pin sharing block
package rtp_pkg;
	// Register byte offsets on the Wishbone bus
	localparam logic [7:0]  ADR_MUX_CTRL   = 8'h00;
	localparam logic [7:0]  ADR_EV_MASK    = 8'h04;
	localparam logic [7:0]  ADR_IRQ_STAT   = 8'h08;
	localparam logic [7:0]  ADR_IRQ_MASK   = 8'h0c;
	localparam logic [7:0]  ADR_PIN_STATE  = 8'h10;
	// Field positions in mux_control_a
	localparam int          MUX_CMP1_BIT   = 1;
	localparam int          MUX_CPU_CLOCK_OUT_BIT = 7;
	localparam int          MUX_TIMER2_PWM_OUT_BIT  = 8;
	localparam int          NUM_CMP        = 3;
	// Field positions in event_irq_mask_a, the interrupt and the state registers
	localparam int          EV_TRIP_EN_BIT = 0;
	localparam int          IRQ_TRIP_BIT   = 0;
	localparam int          IRQ_WDOG_BIT   = 1;
	localparam int          IRQ_BITS       = 2;
	localparam int          ST_TRIP_BIT    = 0;
	localparam int          ST_RSTPIN_BIT  = 1;
	localparam int          ST_WDOG_BIT    = 2;
	localparam int          ST_FORCED_BIT  = 3;
	// Reset values
	localparam logic [15:0] MUX_CTRL_RST   = 16'h0000;
	localparam logic [15:0] EV_MASK_RST    = 16'h0001;
	localparam logic [1:0]  IRQ_RST        = 2'h0;
	localparam logic [15:0] PC_START       = 16'h0000;
	// Watchdog pull length in input_clock cycles (clk_i is the input clock)
	localparam int          WDOG_PULL_CYCLES = 128;
	// Synchroniser lanes: reset pin, port A pins 0..3, pin 22, pin 31
	localparam int          SYN_RST  = 0;
	localparam int          SYN_PA0  = 1;
	localparam int          SYN_P22  = 5;
	localparam int          SYN_P31  = 6;
	localparam int          SYN_W    = 7;
	localparam logic [6:0]  SYN_IDLE = 7'h7f;
endpackage : rtp_pkg

// ### hw/rtp_sync.sv
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module rtp_sync #(
	parameter int          W        = 1,
	parameter logic [W-1:0] IDLE    = '1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= IDLE;
			q_o  <= IDLE;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule : rtp_sync

// ### hw/rtp_wdog_pull.sv
// Stretches a watchdog reset pulse into a fixed-length pin pull
`timescale 1ns/100ps
module rtp_wdog_pull
	import rtp_pkg::*;
#(
	parameter int LEN = WDOG_PULL_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic wd_reset_i,
	output logic      pull_o
);
	localparam int CW = $clog2(LEN + 1);
	localparam logic [CW-1:0] LAST = CW'(LEN - 1);
	logic [CW-1:0] cnt;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pull_o <= 1'b0;
			cnt    <= '0;
		end else if (!pull_o) begin
			pull_o <= wd_reset_i;
			cnt    <= '0;
		end else if (cnt == LAST) begin
			pull_o <= 1'b0;
		end else begin
			cnt <= cnt + CW'(1);
		end
	end
endmodule : rtp_wdog_pull

// ### test/rtp_board.sv
// Board-side model: open-drain reset source and power-stage fault detector
`timescale 1ns/100ps
module rtp_board #(
	parameter int WAKE_IN_CLKS  = 98304,
	parameter int WAKE_CPU_CLKS = 12
) (
	input  wire logic rst_req_i,
	input  wire logic rst_oe_n_i,
	input  wire logic fault_i,
	input  wire logic boot_i,
	output logic      rst_pin_o,
	output logic      trip_n_o
);
	// wired-AND reset line
	// Pull-up holds the line high unless either party pulls it low
	assign rst_pin_o = ~(rst_req_i | ~rst_oe_n_i);
	// wake hold length
	// A wake-up fault must stay low WAKE_IN_CLKS input clocks plus WAKE_CPU_CLKS cpu clocks;
	// the block has no sleep state, so the bench sends only short faults
	// trip high at boot
	// Fault pulls the trip line low, but never while the loader runs
	assign trip_n_o = ~(fault_i & ~boot_i);
endmodule : rtp_board

// ### test/tb.sv
// Self-checking bench for the reset pin, trip and pin sharing block
`timescale 1ns/100ps
module tb;
	import rtp_pkg::*;
	localparam int WDL = 8;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wd_reset_i, pc_step_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i, pa_pin_i, pa_pin_o, pa_pin_oe_n_o, gpio_a_out_i, gpio_a_dir_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [15:0] program_counter_o, m;
	logic [3:0]  gpio_a_in_o;
	logic [2:0]  cmp_i, cmp_en_i;
	logic        wb_ack_o, irq_o, cpu_run_o, rst_pin_i, rst_pin_o, rst_pin_oe_n_o;
	logic        tmr_pin_i, tmr_pin_o, tmr_pin_oe_n_o, timer2_pwm_out_i, gpio_b0_out_i;
	logic        gpio_b0_dir_i, gpio_b0_in_o, ext_irq_one_o, clk_pin_i, clk_pin_o;
	logic        clk_pin_oe_n_o, cpu_clock_out_i, gpio_a7_out_i, gpio_a7_dir_i;
	logic        gpio_a7_in_o, ext_irq_two_o, adc_start_pin_o, capture_input_one_o;
	logic        brd_rst, fault, trip_n, ext_t, ext_c, boot;
	int          fail_count, samples_checked, i, n;

	rtp_pins #(.WDOG_LEN(WDL)) dut (.*);
	rtp_board brd (.rst_req_i(brd_rst), .rst_oe_n_i(rst_pin_oe_n_o), .fault_i(fault),
		.boot_i(boot), .rst_pin_o(rst_pin_i), .trip_n_o(trip_n));

	// Resolve shared pins: pull-ups where released, outside drivers elsewhere
	assign pa_pin_i[0] = trip_n & (pa_pin_oe_n_o[0] | pa_pin_o[0]);
	assign pa_pin_i[3:1] = pa_pin_o[3:1] | pa_pin_oe_n_o[3:1];
	assign tmr_pin_i = tmr_pin_oe_n_o ? ext_t : tmr_pin_o;
	assign clk_pin_i = clk_pin_oe_n_o ? ext_c : clk_pin_o;

	initial begin
		clk_i = 0;
		forever #25 clk_i = ~clk_i;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// Classic single Wishbone cycle, waits for ack under a bound
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= d;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		if (wb_ack_o !== 1'b1) begin
			fail_count++;
			end_sim();
		end
		q = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge clk_i);
	endtask : wb

	// Expected port A drive {oe_n, data} for mux value mm and float f
	function automatic logic [7:0] pa_exp(input logic [15:0] mm, input logic f);
		logic [3:0] o, e;
		o = gpio_a_out_i;
		e = ~gpio_a_dir_i;
		for (int k = 1; k < 4; k++) begin
			if (mm[k]) begin
				o[k] = cmp_i[k-1];
				e[k] = ~cmp_en_i[k-1] | f;
			end
		end
		return {e, o};
	endfunction : pa_exp

	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, wd_reset_i, pc_step_i, brd_rst, fault, boot} = '0;
		{wb_adr_i, wb_dat_i, cmp_i, cmp_en_i, gpio_a_out_i, gpio_a7_out_i} = '0;
		{gpio_a_dir_i, timer2_pwm_out_i, gpio_b0_out_i, gpio_b0_dir_i} = '0;
		{cpu_clock_out_i, gpio_a7_dir_i, ext_t, ext_c} = '0;
		wb_sel_i = 4'hf;
		rst_i = 1;
		fail_count = 0;
		samples_checked = 0;
		void'($urandom(29451));
		repeat (4) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		// Reset values and an unmapped address
		wb(0, ADR_MUX_CTRL, 0);
		chk("mux", q, 32'h0);
		wb(0, ADR_EV_MASK, 0);
		chk("evmask", q, 32'h1);
		wb(1, 8'h14, 32'hffffffff);
		wb(0, 8'h14, 0);
		chk("unmapped", q, 32'h0);
		$display("test regs done");
		// Counter runs from zero, stops and clears under reset
		n = $urandom_range(8, 1);
		pc_step_i <= 1;
		repeat (n) @(posedge clk_i);
		pc_step_i <= 0;
		@(negedge clk_i);
		chk("pc", program_counter_o, n);
		@(posedge clk_i);
		brd_rst <= 1;
		pc_step_i <= 1;
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		chk("pc_hold", program_counter_o, 0);
		chk("run_hold", cpu_run_o, 0);
		@(posedge clk_i);
		brd_rst <= 0;
		pc_step_i <= 0;
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		chk("pc_start", program_counter_o, PC_START);
		chk("run", cpu_run_o, 1);
		$display("test counter done");
		@(posedge clk_i);
		// Watchdog pull length and its interrupt
		wb(1, ADR_IRQ_MASK, 32'h3);
		wd_reset_i <= 1;
		@(posedge clk_i);
		wd_reset_i <= 0;
		n = 0;
		for (i = 0; i < 300; i++) begin
			@(negedge clk_i);
			chk("rst_data", rst_pin_o, 0);
			if (!rst_pin_oe_n_o) n++;
			else if (n > 0) break;
		end
		chk("wd_len", n, WDL);
		repeat (4) @(posedge clk_i);
		wb(0, ADR_IRQ_STAT, 0);
		chk("wd_stat", q, 32'h2);
		chk("wd_irq", irq_o, 1);
		wb(1, ADR_IRQ_STAT, 32'h2);
		chk("irq_clr", irq_o, 0);
		$display("test watchdog done");
		// Trip floats selected compare pins at once and interrupts
		cmp_en_i <= 3'h7;
		cmp_i <= 3'h5;
		wb(1, ADR_MUX_CTRL, 32'h10e);
		boot <= 1;
		fault <= 1;
		@(negedge clk_i);
		chk("boot_hold", {pa_pin_oe_n_o[3:1], tmr_pin_oe_n_o}, 4'h0);
		@(posedge clk_i);
		boot <= 0;
		@(negedge clk_i);
		chk("trip_oe", {pa_pin_oe_n_o[3:1], tmr_pin_oe_n_o}, 4'hf);
		repeat (4) @(posedge clk_i);
		chk("trip_irq", irq_o, 1);
		brd_rst <= 1;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk("trip_halt", {pa_pin_oe_n_o[3:1], tmr_pin_oe_n_o}, 4'hf);
		chk("trip_run", cpu_run_o, 0);
		@(posedge clk_i);
		brd_rst <= 0;
		fault <= 0;
		repeat (4) @(posedge clk_i);
		wb(1, ADR_IRQ_STAT, 32'h1);
		chk("trip_clr", irq_o, 0);
		wb(1, ADR_MUX_CTRL, 32'h10e);
		wb(1, ADR_EV_MASK, 32'h0);
		fault <= 1;
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		chk("trip_off", {pa_pin_oe_n_o[3:1], tmr_pin_oe_n_o}, 4'h0);
		chk("trip_noirq", irq_o, 0);
		@(posedge clk_i);
		fault <= 0;
		wb(1, ADR_EV_MASK, 32'h1);
		$display("test trip done");
		// Random pin routing over 40 random mux selections
		for (i = 0; i < 40; i++) begin
			@(posedge clk_i);
			m = 16'($urandom()) & 16'h018e;
			{cmp_i, cmp_en_i, gpio_a_out_i, gpio_a_dir_i} <= 14'($urandom());
			{timer2_pwm_out_i, gpio_b0_out_i, gpio_b0_dir_i, ext_t} <= 4'($urandom());
			{cpu_clock_out_i, gpio_a7_out_i, gpio_a7_dir_i, ext_c} <= 4'($urandom());
			wb(1, ADR_MUX_CTRL, {16'h0, m});
			repeat (3) @(posedge clk_i);
			@(negedge clk_i);
			chk("pa", {pa_pin_oe_n_o, pa_pin_o}, pa_exp(m, ~pa_pin_i[0]));
			chk("a_in", gpio_a_in_o, pa_pin_i);
			chk("tmr", {tmr_pin_oe_n_o, tmr_pin_o}, m[8] ? {~pa_pin_i[0], timer2_pwm_out_i}
				: {~gpio_b0_dir_i, gpio_b0_out_i});
			chk("xi1", {ext_irq_one_o, gpio_b0_in_o}, {2{tmr_pin_i}});
			chk("clk", {clk_pin_oe_n_o, clk_pin_o}, m[7] ? {1'b0, cpu_clock_out_i}
				: {~gpio_a7_dir_i, gpio_a7_out_i});
			chk("xi2", {ext_irq_two_o, adc_start_pin_o, capture_input_one_o},
				{3{m[7] | clk_pin_i}});
		end
		$display("test routing done");
		end_sim();
	end
endmodule : tb
